// ===== bench/bax_alu_test.sv
// Self-checking bench for the byte ALU slice
`default_nettype none
module bax_alu_test
    import bax_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [7:0] acc;
        logic       c;
        logic       dc;
        logic       z;
        logic       wr;
        logic [6:0] a;
        logic [7:0] r;
        bit         learn;
    } bax_note_t;

    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic       op_valid, result_target_bit, op_done, file_wr_en, op_ready;
    logic       borrow_inverse_bit, half_borrow_bit, null_result_bit;
    bax_op_t    op_code;
    logic [6:0] file_addr, file_wr_addr;
    logic [7:0] literal_value, acc, file_wr_data;
    bax_note_t  q[$];
    logic [7:0] fm[128];
    bit         kn[128];
    logic [7:0] w;
    logic       fc, fdc, fz;
    int         miscompares, total_checks;

    always #2 clk_sys = ~clk_sys;

    bax_alu dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
        .file_addr(file_addr), .literal_value(literal_value), .result_target_bit(result_target_bit),
        .op_ready(op_ready), .op_done(op_done), .acc(acc), .borrow_inverse_bit(borrow_inverse_bit),
        .half_borrow_bit(half_borrow_bit), .null_result_bit(null_result_bit),
        .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));

    bax_decoder_model dec_u (.clk_sys(clk_sys), .op_valid(op_valid), .op_code(op_code),
        .file_addr(file_addr), .literal_value(literal_value), .result_target_bit(result_target_bit));

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp || $isunknown(got)) begin
            miscompares++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp || $isunknown(got)) begin
            miscompares++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_reset;
        cmp8(acc, 8'h00);
        cmp1(borrow_inverse_bit, 1'b0);
        cmp1(half_borrow_bit, 1'b0);
        cmp1(null_result_bit, 1'b0);
        cmp1(file_wr_en, 1'b0);
        cmp1(op_ready, 1'b0);
    endtask

    // ****************************************
    // Result monitor
    // ****************************************
    always @(negedge clk_sys) begin
        bax_note_t n;
        if (op_done === 1'b1) begin
            if (q.size() == 0) begin
                miscompares++;
                $display("[FAIL] %0t unexpected completion", $time);
            end else begin
                n = q.pop_front();
                cmp1(borrow_inverse_bit, n.c);
                cmp1(half_borrow_bit, n.dc);
                cmp1(null_result_bit, n.z);
                cmp1(file_wr_en, n.wr);
                if (n.learn) begin
                    // Unreset file content learned once through an exchange
                    fm[n.a] = {acc[3:0], acc[7:4]};
                    kn[n.a] = 1'b1;
                    w = acc;
                end else begin
                    cmp8(acc, n.acc);
                    cmp8(file_wr_data, n.r);
                    if (n.wr) cmp8({1'b0, file_wr_addr}, {1'b0, n.a});
                end
            end
        end
    end

    // ****************************************
    // Stimulus with reference model
    // ****************************************
    task automatic send(input bax_op_t c, input logic [6:0] a, input logic [7:0] k, input logic d,
                        input bit learn);
        bax_note_t  n;
        logic [7:0] f, r;
        int         j;
        f = fm[a];
        n.wr = 1'b0;
        case (c)
            BAX_OP_SUB_ACC_FROM_FILE: begin
                r = f - w;
                fc = (w <= f);
                fdc = (w[3:0] <= f[3:0]);
            end
            BAX_OP_XOR_LITERAL_INTO_ACC: r = w ^ k;
            BAX_OP_XOR_ACC_WITH_FILE: r = w ^ f;
            default: r = {f[3:0], f[7:4]};
        endcase
        if (c != BAX_OP_NIBBLE_EXCHANGE_FILE) fz = (r == 8'h00);
        if (d && c != BAX_OP_XOR_LITERAL_INTO_ACC) begin
            fm[a] = r;
            n.wr = 1'b1;
        end else begin
            w = r;
        end
        n.acc = w;
        n.r = r;
        n.a = a;
        n.c = fc;
        n.dc = fdc;
        n.z = fz;
        n.learn = learn;
        q.push_back(n);
        @(negedge clk_sys);
        dec_u.issue(c, a, k, d);
        for (j = 0; j < 10 && q.size() != 0; j++) @(posedge clk_sys);
        if (q.size() != 0) begin
            miscompares++;
            $display("[FAIL] %0t operation never completed", $time);
            q.delete();
        end
    endtask

    task automatic run_op(input bax_op_t c, input logic [6:0] a, input logic [7:0] k, input logic d);
        if (c != BAX_OP_XOR_LITERAL_INTO_ACC && !kn[a]) send(BAX_OP_NIBBLE_EXCHANGE_FILE, a, 8'h00, 1'b0, 1'b1);
        send(c, a, k, d, 1'b0);
    endtask

    task automatic restart;
        repeat (8) @(negedge clk_sys);
        chk_reset();
        rst_b = 1'b1;
        repeat (3) @(negedge clk_sys);
        w = 8'h00;
        fc = 1'b0;
        fdc = 1'b0;
        fz = 1'b0;
    endtask

    task automatic random_ops(input int cnt);
        int         i;
        logic [6:0] a;
        for (i = 0; i < cnt; i++) begin
            a = (i % 5 == 0) ? 7'h7f : (i % 5 == 1) ? 7'h00 : 7'($urandom);
            run_op(bax_op_t'(2'($urandom)), a, 8'($urandom), 1'($urandom));
        end
    endtask

    initial begin
        void'($urandom(32'hbbab));
        restart();
        run_op(BAX_OP_XOR_LITERAL_INTO_ACC, 7'h00, 8'hff, 1'b0);
        run_op(BAX_OP_XOR_LITERAL_INTO_ACC, 7'h00, 8'hff, 1'b1);
        run_op(BAX_OP_XOR_LITERAL_INTO_ACC, 7'h00, 8'h00, 1'b0);
        random_ops(40);
        // Accumulator equal to operand gives zero with no borrow
        if (!kn[7'h7f]) send(BAX_OP_NIBBLE_EXCHANGE_FILE, 7'h7f, 8'h00, 1'b0, 1'b1);
        run_op(BAX_OP_XOR_LITERAL_INTO_ACC, 7'h00, w ^ fm[7'h7f], 1'b0);
        run_op(BAX_OP_SUB_ACC_FROM_FILE, 7'h7f, 8'h00, 1'b1);
        run_op(BAX_OP_XOR_ACC_WITH_FILE, 7'h00, 8'h00, 1'b1);
        // Reset in mid-run
        @(negedge clk_sys);
        rst_b = 1'b0;
        restart();
        random_ops(12);
        summarize();
    end

    initial begin
        #100000;
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule
`default_nettype wire

// ===== bench/bax_decoder_model.sv
// Decoder model that issues one byte operation request at a time
`default_nettype none
module bax_decoder_model
    import bax_pkg::*;
(
    // Clock
    input  wire logic             clk_sys,
    // Request to the datapath
    output var  logic             op_valid,
    output var  bax_pkg::bax_op_t op_code,
    output var  logic [6:0]       file_addr,
    output var  logic [7:0]       literal_value,
    output var  logic             result_target_bit
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        op_valid = 1'b0;
        op_code = BAX_OP_SUB_ACC_FROM_FILE;
        file_addr = 7'h00;
        literal_value = 8'h00;
        result_target_bit = 1'b0;
    end

    // Held over one rising edge, then scrambled so stale fields never look valid
    task automatic issue(input bax_op_t c, input logic [6:0] a, input logic [7:0] k, input logic d);
        op_code = c;
        file_addr = a;
        literal_value = k;
        result_target_bit = d;
        op_valid = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        op_code = bax_op_t'(~c);
        file_addr = ~a;
        literal_value = ~k;
        result_target_bit = ~d;
    endtask
endmodule
`default_nettype wire

// ===== include/bax_cfg.svh
// Constants for the byte ALU datapath slice
`ifndef BAX_CFG_SVH
`define BAX_CFG_SVH

`define BAX_DATA_W       8
`define BAX_ADDR_W       7
`define BAX_ADDR_MAX     7'h7f
`define BAX_NIB_LO_HI    3
`define BAX_NIB_HI_LO    4
`define BAX_DEST_ACC     1'b0
`define BAX_DEST_FILE    1'b1
`define BAX_ACC_RST      8'h00
`define BAX_FLAG_RST     1'b0

`endif

// ===== include/bax_pkg.sv
// Types for the byte ALU datapath slice
`default_nettype none
package bax_pkg;
    typedef enum logic [1:0] {
        BAX_OP_SUB_ACC_FROM_FILE,
        BAX_OP_XOR_LITERAL_INTO_ACC,
        BAX_OP_XOR_ACC_WITH_FILE,
        BAX_OP_NIBBLE_EXCHANGE_FILE
    } bax_op_t;
    typedef enum logic [1:0] {
        BAX_ST_IDLE,
        BAX_ST_READ,
        BAX_ST_EXEC
    } bax_state_t;
endpackage
`default_nettype wire

// ===== logic/bax_alu.sv
// Byte ALU slice: subtract, XOR, nibble exchange, destination and status
`include "bax_cfg.svh"
`default_nettype none
module bax_alu
    import bax_pkg::*;
#(
    parameter int DATA_W = `BAX_DATA_W,
    parameter int ADDR_W = `BAX_ADDR_W
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // Instruction from the decoder and ready/done handshake back to it
    input  wire logic              op_valid,
    input  wire bax_pkg::bax_op_t  op_code,
    input  wire logic [ADDR_W-1:0] file_addr,
    input  wire logic [DATA_W-1:0] literal_value,
    input  wire logic              result_target_bit,
    output logic                   op_ready,
    output logic                   op_done,
    // Architectural state
    output logic [DATA_W-1:0]      acc,
    output logic                   borrow_inverse_bit,
    output logic                   half_borrow_bit,
    output logic                   null_result_bit,
    // Register file write observation
    output logic                   file_wr_en,
    output logic [ADDR_W-1:0]      file_wr_addr,
    output logic [DATA_W-1:0]      file_wr_data
);
    import bax_pkg::*;

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ************************************************************
    // Arithmetic helpers
    // ************************************************************
    function automatic logic [DATA_W:0] sub_twos(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        sub_twos = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, 1'b1};
    endfunction

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == '0);
    endfunction

    // ************************************************************
    // Sequencer and operand capture
    // ************************************************************
    bax_state_t        state;
    bax_op_t           cur_op;
    logic [ADDR_W-1:0] cur_addr;
    logic [DATA_W-1:0] cur_lit;
    logic              cur_dest;
    logic [DATA_W-1:0] file_rd_data;
    logic              need_file;
    logic [DATA_W-1:0] result;
    logic              mem_wr_en;

    assign need_file = (op_code != BAX_OP_XOR_LITERAL_INTO_ACC);

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= BAX_ST_IDLE;
        end else begin
            case (state)
                BAX_ST_IDLE: begin
                    if (op_valid) begin
                        state <= need_file ? BAX_ST_READ : BAX_ST_EXEC;
                    end
                end
                BAX_ST_READ: begin
                    state <= BAX_ST_EXEC;
                end
                BAX_ST_EXEC: begin
                    state <= BAX_ST_IDLE;
                end
                default: begin
                    state <= BAX_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cur_op   <= BAX_OP_SUB_ACC_FROM_FILE;
            cur_addr <= '0;
            cur_lit  <= '0;
            cur_dest <= `BAX_DEST_ACC;
        end else if (state == BAX_ST_IDLE && op_valid) begin
            cur_op   <= op_code;
            cur_addr <= file_addr;
            cur_lit  <= literal_value;
            cur_dest <= (op_code == BAX_OP_XOR_LITERAL_INTO_ACC) ? `BAX_DEST_ACC : result_target_bit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            op_ready <= 1'b0;
            op_done  <= 1'b0;
        end else begin
            op_ready <= (state == BAX_ST_IDLE && !op_valid) || state == BAX_ST_EXEC;
            op_done  <= (state == BAX_ST_EXEC);
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    // Written at the execute edge so a request taken with op_done reads the new byte
    assign mem_wr_en = (state == BAX_ST_EXEC && cur_dest == `BAX_DEST_FILE);

    bax_file_mem #(
        .DATA_W (DATA_W),
        .ADDR_W (ADDR_W)
    ) u_file (
        .clk_sys (clk_sys),
        .rd_en   (state == BAX_ST_IDLE && op_valid),
        .rd_addr (file_addr),
        .rd_data (file_rd_data),
        .wr_en   (mem_wr_en),
        .wr_addr (cur_addr),
        .wr_data (result)
    );

    // ************************************************************
    // Datapath
    // ************************************************************
    logic [DATA_W:0]   diff;
    logic [4:0]        diff_lo;

    assign diff    = sub_twos(file_rd_data, acc);
    assign diff_lo = {1'b0, file_rd_data[`BAX_NIB_LO_HI:0]} + {1'b0, ~acc[`BAX_NIB_LO_HI:0]} + 5'h01;

    always_comb begin
        case (cur_op)
            BAX_OP_SUB_ACC_FROM_FILE:    result = diff[DATA_W-1:0];
            BAX_OP_XOR_LITERAL_INTO_ACC: result = acc ^ cur_lit;
            BAX_OP_XOR_ACC_WITH_FILE:    result = acc ^ file_rd_data;
            BAX_OP_NIBBLE_EXCHANGE_FILE: result = {file_rd_data[`BAX_NIB_LO_HI:0],
                                                   file_rd_data[DATA_W-1:`BAX_NIB_HI_LO]};
            default:                     result = '0;
        endcase
    end

    // ************************************************************
    // Destination write
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            acc <= `BAX_ACC_RST;
        end else if (state == BAX_ST_EXEC && cur_dest == `BAX_DEST_ACC) begin
            acc <= result;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            file_wr_en   <= 1'b0;
            file_wr_addr <= '0;
            file_wr_data <= '0;
        end else begin
            file_wr_en <= mem_wr_en;
            if (state == BAX_ST_EXEC) begin
                file_wr_addr <= cur_addr;
                file_wr_data <= result;
            end
        end
    end

    // ************************************************************
    // Status bits
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            borrow_inverse_bit <= `BAX_FLAG_RST;
            half_borrow_bit    <= `BAX_FLAG_RST;
        end else if (state == BAX_ST_EXEC && cur_op == BAX_OP_SUB_ACC_FROM_FILE) begin
            borrow_inverse_bit <= diff[DATA_W];
            half_borrow_bit    <= diff_lo[4];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            null_result_bit <= `BAX_FLAG_RST;
        end else if (state == BAX_ST_EXEC && cur_op != BAX_OP_NIBBLE_EXCHANGE_FILE) begin
            null_result_bit <= is_zero(result);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_sub_carry;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_op == BAX_OP_SUB_ACC_FROM_FILE)
            |=> borrow_inverse_bit == ($past(acc) <= $past(file_rd_data));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("carry wrong after subtract");

    property p_sub_half;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_op == BAX_OP_SUB_ACC_FROM_FILE)
            |=> half_borrow_bit == ($past(acc[3:0]) <= $past(file_rd_data[3:0]));
    endproperty
    a_sub_half: assert property (p_sub_half) else $error("half borrow wrong after subtract");

    property p_sub_value;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_op == BAX_OP_SUB_ACC_FROM_FILE && cur_dest == `BAX_DEST_ACC)
            |=> acc == DATA_W'($past(file_rd_data) - $past(acc));
    endproperty
    a_sub_value: assert property (p_sub_value) else $error("subtract result wrong");

    property p_file_dest;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_dest == `BAX_DEST_FILE)
            |=> file_wr_en && $stable(acc) && file_wr_addr == $past(cur_addr);
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file destination not honoured");

    property p_xorlit;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_op == BAX_OP_XOR_LITERAL_INTO_ACC)
            |=> acc == ($past(acc) ^ $past(cur_lit)) && !file_wr_en && $stable(borrow_inverse_bit)
                && $stable(half_borrow_bit);
    endproperty
    a_xorlit: assert property (p_xorlit) else $error("literal xor wrong");

    property p_swap;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_op == BAX_OP_NIBBLE_EXCHANGE_FILE)
            |=> $stable(null_result_bit) && $stable(borrow_inverse_bit) && $stable(half_borrow_bit)
                && file_wr_data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong");

    property p_xorfile;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_op == BAX_OP_XOR_ACC_WITH_FILE)
            |=> file_wr_data == ($past(acc) ^ $past(file_rd_data)) && $stable(borrow_inverse_bit);
    endproperty
    a_xorfile: assert property (p_xorfile) else $error("file xor wrong");

    property p_zero;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        (state == BAX_ST_EXEC && cur_op != BAX_OP_NIBBLE_EXCHANGE_FILE)
            |=> null_result_bit == (file_wr_data == '0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero bit wrong");

    sequence s_issue;
        state == BAX_ST_IDLE && op_valid;
    endsequence
    property p_done_bound;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        s_issue |-> ##[2:3] op_done;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("operation did not finish in time");
endmodule
`default_nettype wire

// ===== logic/bax_file_mem.sv
// Register file memory with registered read data
`default_nettype none
module bax_file_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    input  wire logic              clk_sys,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output var  logic [DATA_W-1:0] rd_data,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data
);
    // Known power-up content so the far side can learn defined bytes
    logic [DATA_W-1:0] mem [2**ADDR_W] = '{default: '0};

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire
